// ==== verilog/fspm_flash_self_program.sv ====
`timescale 1ns/1ns
`default_nettype none
module fspm_flash_self_program #(
    parameter int WRITE_CYCLES = fspm_pkg::WRITE_NOM_CYC
)(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_tick,
    input wire logic eeprom_write_enable_status,
    input wire logic [11:0] fetch_addr,
    output logic fetch_allowed,
    output logic cpu_halt,
    output logic flash_erase_strobe,
    output logic flash_write_strobe,
    output logic lock_write_strobe,
    output logic [6:0] flash_page,
    output logic [15:0] buffer_data,
    output logic [4:0] buffer_word,
    output logic buffer_load_strobe
);
    fspm_pkg::fspm_state_t state;
    logic [7:0] ctl;
    logic [15:0] zReg;
    logic [15:0] dataReg;
    logic [1:0] fuse;
    logic [11:0] pcLast;
    logic [2:0] armCnt;
    logic [22:0] progCnt;
    logic rwSectionBusy;
    logic [6:0] cmdBits;
    logic awHeld, wHeld;
    logic [31:0] awAddr, wData;
    logic [3:0] wStrb;
    logic storeReq;
    fspm_pkg::fspm_zaddr_t zDec;
    logic [11:0] bootStart;
    logic wrFire;

    // Pointer to counter mapping, bits 15..13 dropped
    function automatic fspm_pkg::fspm_zaddr_t decodeZ(input logic [15:0] z);
        fspm_pkg::fspm_zaddr_t d;
        d.page = z[fspm_pkg::POINTER_COUNTER_TOP_BIT:fspm_pkg::POINTER_PAGE_WORD_TOP_BIT+1];
        d.word = z[fspm_pkg::POINTER_PAGE_WORD_TOP_BIT:1];
        d.byteSel = z[0];
        return d;
    endfunction

    function automatic logic [11:0] bootStartOf(input logic [1:0] sz);
        case (sz)
            2'b11: return fspm_pkg::BOOT_START_11;
            2'b10: return fspm_pkg::BOOT_START_10;
            2'b01: return fspm_pkg::BOOT_START_01;
            default: return fspm_pkg::BOOT_START_00;
        endcase
    endfunction

    function automatic logic inNoReadWhileWrite(input logic [11:0] a);
        return a >= fspm_pkg::NO_READ_WHILE_WRITE_START;
    endfunction

    assign zDec = decodeZ(zReg);
    assign bootStart = bootStartOf(fuse);
    assign cmdBits = ctl[6:0] & 7'h1f;
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wrFire = awHeld && wHeld && !s_axi_bvalid;
    assign storeReq = wrFire && awAddr[7:0] == 8'(fspm_pkg::AXI_DATA_OFS);
    assign fetch_allowed = !rwSectionBusy || inNoReadWhileWrite(fetch_addr);
    // Lock writes leave the whole flash readable
    assign cpu_halt = state == fspm_pkg::ST_PROGRAM && cmdBits != fspm_pkg::CMD_LOCK
        && inNoReadWhileWrite({flash_page, 5'h00});

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 32'h0;
            wData <= 32'h0;
            wStrb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            else if (wrFire)
                awHeld <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            else if (wrFire)
                wHeld <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fspm_pkg::RESP_OKAY;
        end
        else if (wrFire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr[7:0] <= 8'(fspm_pkg::AXI_PC_OFS) && awAddr[1:0] == 2'b00)
                ? fspm_pkg::RESP_OKAY : fspm_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Pointer, data, fuse and counter registers
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            zReg <= 16'h0000;
            dataReg <= 16'h0000;
            fuse <= 2'b00;
            pcLast <= 12'h000;
        end
        else if (wrFire && wStrb[0])
        begin
            case (awAddr[7:0])
                8'(fspm_pkg::AXI_Z_OFS): zReg <= wData[15:0];
                8'(fspm_pkg::AXI_DATA_OFS): dataReg <= wData[15:0];
                8'(fspm_pkg::AXI_FUSE_OFS): fuse <= wData[1:0];
                8'(fspm_pkg::AXI_PC_OFS): pcLast <= wData[fspm_pkg::COUNTER_TOP_BIT:0];
                default: ;
            endcase
        end
    end

    // Command sequencer
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state <= fspm_pkg::ST_IDLE;
            ctl <= fspm_pkg::CTL_RESET;
            armCnt <= 3'h0;
            progCnt <= 23'h0;
            rwSectionBusy <= 1'b0;
            flash_erase_strobe <= 1'b0;
            flash_write_strobe <= 1'b0;
            lock_write_strobe <= 1'b0;
            buffer_load_strobe <= 1'b0;
            flash_page <= 7'h00;
            buffer_word <= 5'h00;
            buffer_data <= 16'h0000;
        end
        else
        begin
            flash_erase_strobe <= 1'b0;
            flash_write_strobe <= 1'b0;
            lock_write_strobe <= 1'b0;
            buffer_load_strobe <= 1'b0;
            case (state)
                fspm_pkg::ST_IDLE:
                begin
                    if (wrFire && awAddr[7:0] == 8'(fspm_pkg::AXI_CTL_OFS) && wStrb[0]
                        && !eeprom_write_enable_status && wData[0])
                    begin
                        ctl <= {1'b0, wData[6:0]};
                        armCnt <= 3'(fspm_pkg::STORE_WINDOW);
                        state <= fspm_pkg::ST_ARMED;
                    end
                end
                fspm_pkg::ST_ARMED:
                begin
                    if (storeReq)
                    begin
                        case (cmdBits)
                            fspm_pkg::CMD_FILL:
                            begin
                                buffer_word <= zDec.word;
                                buffer_data <= wData[15:0];
                                buffer_load_strobe <= 1'b1;
                                ctl[0] <= 1'b0;
                                state <= fspm_pkg::ST_IDLE;
                            end
                            fspm_pkg::CMD_ERASE, fspm_pkg::CMD_WRITE:
                            begin
                                flash_page <= zDec.page;
                                flash_erase_strobe <= cmdBits == fspm_pkg::CMD_ERASE;
                                flash_write_strobe <= cmdBits == fspm_pkg::CMD_WRITE;
                                rwSectionBusy <= 1'b1;
                                progCnt <= 23'(WRITE_CYCLES);
                                state <= fspm_pkg::ST_PROGRAM;
                            end
                            fspm_pkg::CMD_LOCK:
                            begin
                                lock_write_strobe <= 1'b1;
                                progCnt <= 23'(WRITE_CYCLES);
                                state <= fspm_pkg::ST_PROGRAM;
                            end
                            fspm_pkg::CMD_REEN:
                            begin
                                rwSectionBusy <= 1'b0;
                                ctl[0] <= 1'b0;
                                state <= fspm_pkg::ST_IDLE;
                            end
                            default:
                            begin
                                ctl[0] <= 1'b0;
                                state <= fspm_pkg::ST_IDLE;
                            end
                        endcase
                    end
                    else if (armCnt == 3'h1)
                    begin
                        ctl[0] <= 1'b0;
                        state <= fspm_pkg::ST_IDLE;
                    end
                    else
                        armCnt <= armCnt - 3'h1;
                end
                fspm_pkg::ST_PROGRAM:
                begin
                    if (osc_tick)
                    begin
                        if (progCnt <= 23'h1)
                        begin
                            ctl[0] <= 1'b0;
                            state <= fspm_pkg::ST_IDLE;
                        end
                        else
                            progCnt <= progCnt - 23'h1;
                    end
                end
                default: state <= fspm_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= fspm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= fspm_pkg::RESP_OKAY;
            case (s_axi_araddr[7:0])
                8'(fspm_pkg::AXI_CTL_OFS):
                    s_axi_rdata <= {24'h0, 1'b0, rwSectionBusy, 1'b0, ctl[4:0]};
                8'(fspm_pkg::AXI_Z_OFS): s_axi_rdata <= {16'h0, zReg};
                8'(fspm_pkg::AXI_DATA_OFS): s_axi_rdata <= {16'h0, dataReg};
                8'(fspm_pkg::AXI_STATUS_OFS): s_axi_rdata <= {8'h0, bootStart, 1'b0, fetch_allowed,
                    cpu_halt, flash_page, 2'b00};
                8'(fspm_pkg::AXI_FUSE_OFS): s_axi_rdata <= {30'h0, fuse};
                8'(fspm_pkg::AXI_PC_OFS): s_axi_rdata <= {20'h0, pcLast};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= fspm_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule
`default_nettype wire

// ==== verilog/fspm_pkg.sv ====
`default_nettype none
package fspm_pkg;
    localparam int PC_W = 12;
    localparam int COUNTER_TOP_BIT = 11;
    localparam int PAGE_WORD_TOP_BIT = 4;
    localparam int POINTER_COUNTER_TOP_BIT = 12;
    localparam int POINTER_PAGE_WORD_TOP_BIT = 5;
    localparam int PAGE_W = 7;
    localparam int WORD_W = 5;
    localparam logic [11:0] NO_READ_WHILE_WRITE_START = 12'hc00;
    localparam logic [11:0] BOOT_START_11 = 12'hf80;
    localparam logic [11:0] BOOT_START_10 = 12'hf00;
    localparam logic [11:0] BOOT_START_01 = 12'he00;
    localparam logic [11:0] BOOT_START_00 = 12'hc00;
    // Control register bits
    localparam int CTL_ENABLE_POS = 0;
    localparam int CTL_ERASE_POS = 1;
    localparam int CTL_WRITE_POS = 2;
    localparam int CTL_LOCK_POS = 3;
    localparam int CTL_REEN_POS = 4;
    localparam int CTL_BUSY_POS = 6;
    localparam logic [6:0] CMD_FILL = 7'h01;
    localparam logic [6:0] CMD_ERASE = 7'h03;
    localparam logic [6:0] CMD_WRITE = 7'h05;
    localparam logic [6:0] CMD_LOCK = 7'h09;
    localparam logic [6:0] CMD_REEN = 7'h11;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam int STORE_WINDOW = 4;
    // Timing in the oscillator domain, counted in 50 MHz cycles
    localparam real CLK_MHZ = 50.0;
    localparam real WRITE_MIN_MS = 3.7;
    localparam real WRITE_MAX_MS = 4.5;
    localparam real WRITE_NOM_MS = 4.1;
    localparam int WRITE_MIN_CYC = int'($ceil(WRITE_MIN_MS * 1000.0 * CLK_MHZ));
    localparam int WRITE_MAX_CYC = int'($floor(WRITE_MAX_MS * 1000.0 * CLK_MHZ));
    localparam int WRITE_NOM_CYC = int'(WRITE_NOM_MS * 1000.0 * CLK_MHZ);
    localparam int AXI_CTL_OFS = 0;
    localparam int AXI_Z_OFS = 4;
    localparam int AXI_DATA_OFS = 8;
    localparam int AXI_STATUS_OFS = 12;
    localparam int AXI_FUSE_OFS = 16;
    localparam int AXI_PC_OFS = 20;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum {ST_IDLE, ST_ARMED, ST_PROGRAM} fspm_state_t;
    typedef struct packed {
        logic [PAGE_W-1:0] page;
        logic [WORD_W-1:0] word;
        logic byteSel;
    } fspm_zaddr_t;
endpackage
`default_nettype wire

// ==== testbench/fspm_checker_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module fspm_checker #(
    parameter int WRITE_CYCLES = 20
)(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic osc_tick,
    input wire logic [11:0] fetch_addr,
    input wire logic fetch_allowed,
    input wire logic cpu_halt,
    input wire logic flash_erase_strobe,
    input wire logic flash_write_strobe,
    input wire logic lock_write_strobe,
    input wire logic buffer_load_strobe,
    input wire logic [6:0] flash_page
);
    int tickCnt;
    int sinceW;
    logic anyStb;
    assign anyStb = flash_erase_strobe || flash_write_strobe || lock_write_strobe
        || buffer_load_strobe;
    // Oscillator ticks seen while the core is halted
    always_ff @(posedge ref_clk)
    begin
        if (srst || !cpu_halt) tickCnt <= 0;
        else if (osc_tick) tickCnt <= tickCnt + 1;
    end
    always_ff @(posedge ref_clk)
    begin
        if (srst || (s_axi_wvalid && s_axi_wready)) sinceW <= 0;
        else if (sinceW < 9) sinceW <= sinceW + 1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    protected_fetch_a: assert property (fetch_addr >= 12'hc00 |-> fetch_allowed)
        else $error("fetch refused in the protected range");
    erase_blocks_a: assert property (flash_erase_strobe && fetch_addr < 12'hc00
        |-> ##[0:2] !fetch_allowed) else $error("erase left the shared section readable");
    strobe_onehot_a: assert property ($onehot0({flash_erase_strobe, flash_write_strobe,
        lock_write_strobe, buffer_load_strobe})) else $error("two strobes at once");
    strobe_pulse_a: assert property ((flash_erase_strobe || flash_write_strobe)
        |=> !(flash_erase_strobe || flash_write_strobe)) else $error("strobe longer than one cycle");
    strobe_cause_a: assert property (anyStb |-> sinceW < 3)
        else $error("strobe without a recent store");
    halt_length_a: assert property ($fell(cpu_halt) |-> tickCnt == WRITE_CYCLES)
        else $error("halt length differs from oscillator count");
    halt_page_a: assert property (cpu_halt |-> flash_page >= 7'h60)
        else $error("halt while programming a shared page");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cover property (flash_erase_strobe);
    cover property ($rose(cpu_halt));
    cover property (lock_write_strobe);
endmodule
`default_nettype wire

// ==== testbench/fspm_osc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fspm_osc_model (
    input wire logic ref_clk,
    input wire logic srst,
    output logic osc_tick
);
    logic [1:0] phase;
    // Slow oscillator, one tick every third cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst || phase == 2'h2) phase <= 2'h0;
        else phase <= phase + 2'h1;
    end
    assign osc_tick = (phase == 2'h2);
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, eepromBusy = 1'b0;
    logic [11:0] fetchAddr = 12'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, oscTick;
    logic fetchAllowed, cpuHalt, eraseStb, writeStb, lockStb, loadStb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rdv;
    logic [6:0] flashPage, pg;
    logic [4:0] bufWord;
    logic [15:0] bufData, dv;
    logic [63:0] rq[$], sq[$], e;
    logic [11:0] bootTab[4] = '{12'hc00, 12'he00, 12'hf00, 12'hf80};
    logic [1:0] pq[$];
    int nMismatch = 0, checkCount = 0;
    always #10 ref_clk = ~ref_clk;
    fspm_osc_model fspm_osc_model_inst (.ref_clk(ref_clk), .srst(srst), .osc_tick(oscTick));
    fspm_flash_self_program #(.WRITE_CYCLES(20)) fspm_flash_self_program_inst (
        .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(1'b1), .osc_tick(oscTick), .eeprom_write_enable_status(eepromBusy),
        .fetch_addr(fetchAddr), .fetch_allowed(fetchAllowed), .cpu_halt(cpuHalt),
        .flash_erase_strobe(eraseStb), .flash_write_strobe(writeStb), .lock_write_strobe(lockStb),
        .flash_page(flashPage), .buffer_data(bufData), .buffer_word(bufWord),
        .buffer_load_strobe(loadStb));
    task automatic chk(input logic [31:0] seen, exp);
        checkCount++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        pq.push_back((a[7:0] <= 8'h14 && a[1:0] == 2'b00) ? 2'b00 : 2'b10);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge ref_clk);
            if (!aw && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (!w && s_axi_wready) s_axi_wvalid <= 1'b0;
            aw = aw || s_axi_awready;
            w = w || s_axi_wready;
        end
        do @(posedge ref_clk); while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [31:0] a, exp, m);
        rq.push_back({m, exp});
        pq.push_back((a[7:0] <= 8'h14 && a[1:0] == 2'b00) ? 2'b00 : 2'b10);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        rdv = s_axi_rdata;
    endtask
    task automatic poll();
        do rd(32'h0, 32'h0, 32'h0); while (rdv[0]);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] z, d, input logic [63:0] x);
        poll();
        while (eepromBusy) @(posedge ref_clk);
        wr(32'h4, {16'h0, z});
        if (x[63:32] != 32'h0) sq.push_back(x);
        wr(32'h0, {24'h0, c});
        wr(32'h8, {16'h0, d});
    endtask
    task automatic endOfTest();
        if (nMismatch == 0 && checkCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        if (s_axi_bvalid || s_axi_rvalid)
            chk({30'h0, s_axi_bvalid ? s_axi_bresp : s_axi_rresp}, {30'h0, pq.pop_front()});
        if (s_axi_rvalid)
        begin
            e = rq.pop_front();
            chk(s_axi_rdata & e[63:32], e[31:0]);
        end
        if ({eraseStb, writeStb, lockStb, loadStb} != 4'h0)
        begin
            e = (sq.size() > 0) ? sq.pop_front() : {32'hffffffff, 32'h0};
            chk({eraseStb, writeStb, lockStb, loadStb, flashPage, bufWord, bufData} & e[63:32],
                e[31:0]);
        end
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        nMismatch++;
        endOfTest();
    end
    initial
    begin
        void'($urandom(32'h38d8));
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(32'h0, 32'h0, 32'hff);
        for (int f = 0; f < 4; f++)
        begin
            wr(32'h10, f);
            rd(32'hc, {8'h0, bootTab[f], 12'h0}, 32'h00fff000);
        end
        wr(32'h14, 32'hffffffff);
        rd(32'h14, 32'h00000fff, 32'hffffffff);
        wr(32'h1c, 32'h0);
        rd(32'h18, 32'h0, 32'hffffffff);
        pg = 7'($urandom);
        for (int i = 0; i < 3; i++)
        begin
            dv = 16'($urandom);
            cmd(8'h01, {3'($urandom), pg, 5'(i), 1'b0}, dv,
                {4'hf, 7'h0, 5'h1f, 16'hffff, 4'h1, 7'h0, 5'(i), dv});
        end
        pg = 7'($urandom_range(95));
        fetchAddr <= 12'($urandom_range(3071));
        cmd(8'h03, {3'h7, pg, 6'h0}, 16'h0, {4'hf, 7'h7f, 21'h0, 4'h8, pg, 21'h0});
        rd(32'hc, 32'h0, 32'h400);
        fetchAddr <= 12'hc00 + 12'($urandom_range(1023));
        poll();
        rd(32'h0, 32'h40, 32'h40);
        cmd(8'h11, 16'h0, 16'h0, 64'h0);
        fetchAddr <= 12'($urandom_range(3071));
        rd(32'h0, 32'h0, 32'h40);
        rd(32'hc, 32'h400, 32'h400);
        pg = 7'(96 + $urandom_range(31));
        cmd(8'h05, {3'h0, pg, 6'h0}, 16'h0, {4'hf, 7'h7f, 21'h0, 4'h4, pg, 21'h0});
        rd(32'hc, {22'h0, 1'b1, pg, 2'b00}, 32'h3fc);
        cmd(8'h11, 16'h0, 16'h0, 64'h0);
        cmd(8'h09, 16'h1, 16'h0, {4'hf, 28'h0, 4'h2, 28'h0});
        rd(32'hc, 32'h400, 32'h600);
        poll();
        wr(32'h0, 32'h3);
        repeat (6) @(posedge ref_clk);
        wr(32'h8, 32'h0);
        poll();
        eepromBusy <= 1'b1;
        wr(32'h0, 32'h3);
        wr(32'h8, 32'h0);
        eepromBusy <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk(sq.size(), 32'h0);
        endOfTest();
    end
endmodule
bind fspm_flash_self_program fspm_checker #(.WRITE_CYCLES(WRITE_CYCLES)) fspm_checker_inst (
    .ref_clk, .srst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_wvalid,
    .s_axi_wready, .osc_tick, .fetch_addr, .fetch_allowed, .cpu_halt, .flash_erase_strobe,
    .flash_write_strobe, .lock_write_strobe, .buffer_load_strobe, .flash_page);
`default_nettype wire
